// ===== common/host_signals_pkg.sv
package host_signals_pkg;

  // Node role encoding on i_role
  localparam logic [1:0] ROLE_BASE   = 2'h0;
  localparam logic [1:0] ROLE_ROUTER = 2'h1;
  localparam logic [1:0] ROLE_REMOTE = 2'h2;

  // General-purpose pin map
  localparam int NUM_IO           = 6;
  localparam int IO_PENDING       = 3;
  localparam int IO_CTS           = 4;
  localparam int IO_RTS           = 5;
  localparam int FIRST_SAMPLED_IO = 2;

  // Link supervision
  localparam int         REG_CNT_W         = 16;
  localparam int         MISS_CNT_W        = 6;
  localparam logic [5:0] BEACON_MISS_LIMIT = 6'h32;

  // Timing
  localparam int SYS_CLK_MHZ  = 250;
  localparam int ACT_PULSE_US = 50000;
  localparam int ACT_PULSE_CYC = ACT_PULSE_US * SYS_CLK_MHZ;
  localparam int ACT_CNT_W    = 24;

  // Pin levels and reset values
  localparam logic SERIAL_IDLE  = 1'h1;
  localparam logic LINK_DOWN_N  = 1'h1;
  localparam logic LINK_UP_N    = 1'h0;
  localparam logic ACT_OFF      = 1'h0;
  localparam logic ACT_ON       = 1'h1;
  localparam logic CTS_READY    = 1'h0;
  localparam logic CTS_BUSY     = 1'h1;
  localparam logic RTS_HOLD     = 1'h1;
  localparam logic WAKE_LEVEL   = 1'h0;

endpackage : host_signals_pkg

// ===== design/host_signals.sv
`timescale 1ns/1ps

// Notes on behaviour
// R1: Base raises link indication on any valid packet; drops after registration time-out.
// R2: Router or remote raises link on hop sync; drops after 50 missed beacon hops.
// R3: Base pulses activity on each valid packet received.
// R4: Remote pulses activity on each packet transmitted.
// R5: Router pulses activity on valid upstream receive or downstream transmit.
// R6: Link and activity pins may become diagnostic serial out and in.
// R7: Input user pins offer pull-up and optional wake from sleep.
// R8: Output user pins drive a configured power-on level until software writes.
// R9: Separate sleep direction, pull-up and level per user pin, applied while asleep.
// R10: Pins 2 to 5 test wake only at the sleep ADC sampling tick.
// R11: In flow control, clear-to-send low while input can be accepted, else high.
// R12: Host stops sending while clear-to-send is high.
// R13: Host drives request-to-send low to let device send, high to hold off.
// R14: Device stops serial output to host while request-to-send is high; here o_tx_permit drops but o_radio_serial_out is not gated.
// R15: SPI slave mode drives pending flag high while data waits for master.
// R16: Pending and flow pins act as ordinary user pins when not special.
// R17: Host-bound serial on dedicated output, host serial in on dedicated input.
// R18: Low level on module reset pin resets the whole module; here a high level on i_reset resets it.
// R19: Link indication is active low on its pin.
// R20: Activity pulse has fixed visible length and retriggers on new events.
module host_signals #(
  parameter int ACT_PULSE_CYCLES = host_signals_pkg::ACT_PULSE_CYC
) (
  input  wire logic                                 i_sys_clk,
  input  wire logic                                 i_reset,
  // Role and radio events
  input  wire logic [1:0]                           i_role,
  input  wire logic                                 i_rx_valid_pkt,
  input  wire logic                                 i_rx_upstream_pkt,
  input  wire logic                                 i_tx_pkt,
  input  wire logic                                 i_tx_downstream_pkt,
  input  wire logic                                 i_hop_sync_gained,
  input  wire logic                                 i_hop_tick,
  input  wire logic                                 i_beacon_rx,
  input  wire logic                                 i_timeout_tick,
  input  wire logic [host_signals_pkg::REG_CNT_W-1:0] i_reg_timeout,
  // Indicator pins and diagnostic port
  input  wire logic                                 i_diag_mode,
  input  wire logic                                 i_diag_serial_out_data,
  output logic                                      o_diag_serial_in_data,
  output logic                                      o_link_up_n,
  input  wire logic                                 i_traffic_indicator,
  output logic                                      o_traffic_indicator,
  output logic                                      o_traffic_indicator_oe,
  // Primary serial data
  input  wire logic                                 i_core_tx_serial,
  output logic                                      o_radio_serial_out,
  input  wire logic                                 i_radio_serial_in,
  output logic                                      o_core_rx_serial,
  output logic                                      o_tx_permit,
  // Flow control and SPI slave
  input  wire logic                                 i_flow_ctl_en,
  input  wire logic                                 i_rx_can_accept,
  input  wire logic                                 i_spi_slave_en,
  input  wire logic                                 i_spi_data_ready,
  // User pins and their configuration
  input  wire logic [host_signals_pkg::NUM_IO-1:0]  i_user_io,
  output logic      [host_signals_pkg::NUM_IO-1:0]  o_user_io,
  output logic      [host_signals_pkg::NUM_IO-1:0]  o_user_io_oe,
  output logic      [host_signals_pkg::NUM_IO-1:0]  o_user_io_pullup,
  output logic      [host_signals_pkg::NUM_IO-1:0]  o_user_io_in,
  input  wire logic [host_signals_pkg::NUM_IO-1:0]  i_io_dir_out,
  input  wire logic [host_signals_pkg::NUM_IO-1:0]  i_io_pullup,
  input  wire logic [host_signals_pkg::NUM_IO-1:0]  i_io_poweron_level,
  input  wire logic                                 i_io_wr,
  input  wire logic [host_signals_pkg::NUM_IO-1:0]  i_io_wr_level,
  input  wire logic [host_signals_pkg::NUM_IO-1:0]  i_io_wake_en,
  input  wire logic                                 i_sleep,
  input  wire logic [host_signals_pkg::NUM_IO-1:0]  i_sleep_dir_out,
  input  wire logic [host_signals_pkg::NUM_IO-1:0]  i_sleep_pullup,
  input  wire logic [host_signals_pkg::NUM_IO-1:0]  i_sleep_level,
  input  wire logic                                 i_adc_sample_tick,
  output logic                                      o_wake
);

  localparam int N = host_signals_pkg::NUM_IO;
  localparam int AW = host_signals_pkg::ACT_CNT_W;

  generate
    if (ACT_PULSE_CYCLES < 1 || ACT_PULSE_CYCLES >= (1 << AW)) begin : g_bad_pulse
      $error("ACT_PULSE_CYCLES out of range");
    end
  endgenerate

  typedef struct packed {
    logic                                   link_up;
    logic [host_signals_pkg::REG_CNT_W-1:0] reg_cnt;
    logic [host_signals_pkg::MISS_CNT_W-1:0] miss_cnt;
    logic                                   beacon_seen;
    logic [AW-1:0]                          act_cnt;
    logic                                   levels_loaded;
    logic [N-1:0]                           out_level;
    logic                                   link_pin;
    logic                                   act_pin;
    logic                                   act_oe;
    logic                                   diag_serial_in;
    logic                                   ser_out;
    logic                                   ser_in;
    logic [N-1:0]                           io_o;
    logic [N-1:0]                           io_oe;
    logic [N-1:0]                           io_pu;
    logic [N-1:0]                           io_in;
    logic                                   wake;
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  // Pin carries its special function instead of the user-pin function
  function automatic logic special_sel(input int idx, input logic spi_en, input logic flow_en);
    special_sel = (idx == host_signals_pkg::IO_PENDING && spi_en) ||
                  ((idx == host_signals_pkg::IO_CTS || idx == host_signals_pkg::IO_RTS)
                   && flow_en);
  endfunction : special_sel

  logic act_event;
  logic rts_hold;

  always_comb begin
    unique case (i_role)
      host_signals_pkg::ROLE_BASE:   act_event = i_rx_valid_pkt;                         // R3
      host_signals_pkg::ROLE_REMOTE: act_event = i_tx_pkt;                               // R4
      host_signals_pkg::ROLE_ROUTER: act_event = i_rx_upstream_pkt | i_tx_downstream_pkt; // R5
      default:                       act_event = 1'b0;
    endcase
  end

  assign rts_hold = i_flow_ctl_en &&
                    (i_user_io[host_signals_pkg::IO_RTS] == host_signals_pkg::RTS_HOLD);
  assign o_tx_permit = !rts_hold; // R14 R13

  always_comb begin
    logic       dir;
    logic       pu;
    logic       lvl;
    logic [N-1:0] wake_hit;
    dir = 1'b0;
    pu = 1'b0;
    lvl = 1'b0;
    wake_hit = '0;
    nxt_s = s_ff;

    // Link supervision
    if (i_role == host_signals_pkg::ROLE_BASE) begin
      if (i_rx_valid_pkt) begin
        nxt_s.link_up = 1'b1; // R1
        nxt_s.reg_cnt = i_reg_timeout;
      end else if (s_ff.link_up && i_timeout_tick) begin
        if (s_ff.reg_cnt <= 16'h0001) begin
          nxt_s.link_up = 1'b0; // R1
          nxt_s.reg_cnt = '0;
        end else begin
          nxt_s.reg_cnt = s_ff.reg_cnt - 16'h0001;
        end
      end
      nxt_s.miss_cnt = '0;
    end else begin
      if (i_hop_tick) begin
        // A beacon on the tick itself counts for this hop only
        nxt_s.beacon_seen = 1'b0;
        if (s_ff.beacon_seen || i_beacon_rx || i_hop_sync_gained) begin
          nxt_s.miss_cnt = '0;
        end else if (s_ff.link_up) begin
          nxt_s.miss_cnt = s_ff.miss_cnt + 6'h01;
          if (s_ff.miss_cnt + 6'h01 >= host_signals_pkg::BEACON_MISS_LIMIT) begin
            nxt_s.link_up = 1'b0; // R2
            nxt_s.miss_cnt = '0;
          end
        end
      end else if (i_beacon_rx) begin
        nxt_s.beacon_seen = 1'b1;
      end
      if (i_hop_sync_gained) begin
        nxt_s.link_up = 1'b1; // R2
        nxt_s.miss_cnt = '0;
      end
    end

    // Activity stretch, retriggered by every new event
    if (act_event) begin
      nxt_s.act_cnt = AW'(ACT_PULSE_CYCLES); // R20
    end else if (s_ff.act_cnt != '0) begin
      nxt_s.act_cnt = s_ff.act_cnt - AW'(1);
    end

    // Indicator pins or diagnostic port
    if (i_diag_mode) begin
      nxt_s.link_pin = i_diag_serial_out_data; // R6
      nxt_s.act_oe = 1'b0;
      nxt_s.act_pin = host_signals_pkg::ACT_OFF;
      nxt_s.diag_serial_in = i_traffic_indicator; // R6
    end else begin
      nxt_s.link_pin = s_ff.link_up ? host_signals_pkg::LINK_UP_N
                                    : host_signals_pkg::LINK_DOWN_N; // R19
      nxt_s.act_oe = 1'b1;
      nxt_s.act_pin = (s_ff.act_cnt != '0) ? host_signals_pkg::ACT_ON
                                           : host_signals_pkg::ACT_OFF;
      nxt_s.diag_serial_in = host_signals_pkg::SERIAL_IDLE;
    end

    // Dedicated serial data pins
    nxt_s.ser_out = i_core_tx_serial; // R17
    nxt_s.ser_in = i_radio_serial_in; // R17

    // Output levels: power-on value first, then software writes
    if (!s_ff.levels_loaded) begin
      nxt_s.out_level = i_io_poweron_level; // R8
      nxt_s.levels_loaded = 1'b1;
    end else if (i_io_wr) begin
      nxt_s.out_level = i_io_wr_level; // R8
    end

    // User pins
    for (int i = 0; i < N; i++) begin
      dir = i_sleep ? i_sleep_dir_out[i] : i_io_dir_out[i]; // R9
      pu = i_sleep ? i_sleep_pullup[i] : i_io_pullup[i]; // R9
      lvl = i_sleep ? i_sleep_level[i] : s_ff.out_level[i]; // R9
      if (special_sel(i, i_spi_slave_en, i_flow_ctl_en)) begin
        if (i == host_signals_pkg::IO_PENDING) begin
          nxt_s.io_oe[i] = 1'b1;
          nxt_s.io_o[i] = i_spi_data_ready; // R15
          nxt_s.io_pu[i] = 1'b0;
        end else if (i == host_signals_pkg::IO_CTS) begin
          nxt_s.io_oe[i] = 1'b1;
          nxt_s.io_o[i] = i_rx_can_accept ? host_signals_pkg::CTS_READY
                                          : host_signals_pkg::CTS_BUSY; // R11
          nxt_s.io_pu[i] = 1'b0;
        end else begin
          nxt_s.io_oe[i] = 1'b0;
          nxt_s.io_o[i] = 1'b0;
          nxt_s.io_pu[i] = pu;
        end
      end else begin
        nxt_s.io_oe[i] = dir; // R16
        nxt_s.io_o[i] = dir ? lvl : 1'b0;
        nxt_s.io_pu[i] = !dir && pu; // R7
        // Pins 0 and 1 wake at once; the rest only on the ADC tick
        wake_hit[i] = i_sleep && !dir && i_io_wake_en[i] &&
                      (i_user_io[i] == host_signals_pkg::WAKE_LEVEL) &&
                      (i < host_signals_pkg::FIRST_SAMPLED_IO || i_adc_sample_tick); // R7 R10
      end
      nxt_s.io_in[i] = i_user_io[i];
    end
    nxt_s.wake = |wake_hit;

    if (i_reset) begin // R18
      nxt_s = '0;
      nxt_s.link_pin = host_signals_pkg::LINK_DOWN_N;
      nxt_s.act_oe = 1'b1;
      nxt_s.diag_serial_in = host_signals_pkg::SERIAL_IDLE;
      nxt_s.ser_out = host_signals_pkg::SERIAL_IDLE;
      nxt_s.ser_in = host_signals_pkg::SERIAL_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    s_ff <= nxt_s;
  end

  assign o_link_up_n            = s_ff.link_pin;
  assign o_traffic_indicator    = s_ff.act_pin;
  assign o_traffic_indicator_oe = s_ff.act_oe;
  assign o_diag_serial_in_data         = s_ff.diag_serial_in;
  assign o_radio_serial_out     = s_ff.ser_out;
  assign o_core_rx_serial       = s_ff.ser_in;
  assign o_user_io              = s_ff.io_o;
  assign o_user_io_oe           = s_ff.io_oe;
  assign o_user_io_pullup       = s_ff.io_pu;
  assign o_user_io_in           = s_ff.io_in;
  assign o_wake                 = s_ff.wake;

  base_link_set_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R1
    (i_role == host_signals_pkg::ROLE_BASE && i_rx_valid_pkt && !i_diag_mode)
      ##1 !i_diag_mode |=> o_link_up_n == host_signals_pkg::LINK_UP_N)
    else $error("base link not raised on packet");

  base_link_drop_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R1
    (i_role == host_signals_pkg::ROLE_BASE && !i_rx_valid_pkt && i_timeout_tick &&
     s_ff.link_up && s_ff.reg_cnt == 16'h0001) |=> !s_ff.link_up)
    else $error("base link not dropped at time-out");

  sync_link_set_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R2
    (i_role != host_signals_pkg::ROLE_BASE && i_hop_sync_gained) |=> s_ff.link_up)
    else $error("link not raised on hop sync");

  miss_limit_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R2
    s_ff.miss_cnt < host_signals_pkg::BEACON_MISS_LIMIT)
    else $error("missed hop count passed limit");

  act_retrigger_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R20
    act_event |=> s_ff.act_cnt == AW'(ACT_PULSE_CYCLES))
    else $error("activity pulse not retriggered");

  act_pin_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R3
    (act_event && !i_diag_mode) ##1 !i_diag_mode |=>
      o_traffic_indicator == host_signals_pkg::ACT_ON)
    else $error("activity pin not lit after event");

  diag_swap_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R6
    i_diag_mode |=> (o_link_up_n == $past(i_diag_serial_out_data)) && !o_traffic_indicator_oe)
    else $error("diagnostic port not mapped");

  cts_level_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R11
    i_flow_ctl_en |=> o_user_io_oe[host_signals_pkg::IO_CTS] &&
      (o_user_io[host_signals_pkg::IO_CTS] == !$past(i_rx_can_accept)))
    else $error("clear-to-send level wrong");

  pending_flag_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R15
    (i_spi_slave_en && i_spi_data_ready) |=> o_user_io[host_signals_pkg::IO_PENDING])
    else $error("pending flag not raised");

  wake_sampled_a: assert property (@(posedge i_sys_clk) disable iff (i_reset) // R10
    (!i_adc_sample_tick && !(i_sleep && !i_sleep_dir_out[0] && i_io_wake_en[0]) &&
     !(i_sleep && !i_sleep_dir_out[1] && i_io_wake_en[1])) |=> !o_wake)
    else $error("sampled pin woke outside tick");

endmodule : host_signals

// ===== verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_cts_n,
  input  wire logic i_send,
  input  wire logic i_bit,
  input  wire logic i_hold,
  output logic      o_txd,
  output logic      o_rts_n
);
  // Line rests high between bits, as a UART does
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_txd   <= 1'h1;
      o_rts_n <= 1'h1;
    end else begin
      o_txd   <= (i_send && !i_cts_n) ? i_bit : 1'h1;
      o_rts_n <= i_hold;
    end
  end
endmodule : host_model

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int ACT = 8;
  logic i_sys_clk, i_reset, i_diag_mode, i_diag_serial_out_data, i_core_tx_serial, i_flow_ctl_en;
  logic i_rx_can_accept, i_spi_slave_en, i_spi_data_ready, i_sleep, diag_pad, h_send, h_bit;
  logic i_rx_valid_pkt, i_rx_upstream_pkt, i_tx_pkt, i_tx_downstream_pkt, i_hop_sync_gained;
  logic i_hop_tick, i_beacon_rx, i_timeout_tick, i_adc_sample_tick, i_io_wr, h_hold, rts_n;
  logic [1:0] i_role;
  logic [9:0] ev;
  logic [15:0] i_reg_timeout;
  logic [5:0] i_io_dir_out, i_io_pullup, i_io_poweron_level, i_io_wr_level, i_io_wake_en;
  logic [5:0] i_sleep_dir_out, i_sleep_pullup, i_sleep_level, ext, ext_en, i_user_io;
  logic o_diag_serial_in_data, o_link_up_n, o_traffic_indicator, o_traffic_indicator_oe;
  logic i_traffic_indicator, o_radio_serial_out, o_core_rx_serial, o_tx_permit, o_wake;
  logic i_radio_serial_in;
  logic [5:0] o_user_io, o_user_io_oe, o_user_io_pullup, o_user_io_in;
  int bad_count, tests_run;
  logic [1:0] t_role [6] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h0, 2'h2};
  logic [9:0] t_ev [6] = '{10'h001, 10'h004, 10'h002, 10'h008, 10'h004, 10'h001};
  logic t_on [6] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};

  assign {i_io_wr, i_adc_sample_tick, i_timeout_tick, i_beacon_rx, i_hop_tick, i_hop_sync_gained,
          i_tx_downstream_pkt, i_tx_pkt, i_rx_upstream_pkt, i_rx_valid_pkt} = ev;
  assign i_traffic_indicator = o_traffic_indicator_oe ? o_traffic_indicator : diag_pad;
  // Undriven pad without pull-up reads low here
  for (genvar k = 0; k < 6; k++) begin : g_pad
    assign i_user_io[k] = o_user_io_oe[k] ? o_user_io[k] : (k == 5 && i_flow_ctl_en) ? rts_n
                        : ext_en[k] ? ext[k] : o_user_io_pullup[k];
  end

  host_signals #(.ACT_PULSE_CYCLES(ACT)) i_dut (.i_sys_clk, .i_reset, .i_role, .i_rx_valid_pkt,
    .i_rx_upstream_pkt, .i_tx_pkt, .i_tx_downstream_pkt, .i_hop_sync_gained, .i_hop_tick,
    .i_beacon_rx, .i_timeout_tick, .i_reg_timeout, .i_diag_mode, .i_diag_serial_out_data,
    .o_diag_serial_in_data, .o_link_up_n, .i_traffic_indicator, .o_traffic_indicator,
    .o_traffic_indicator_oe, .i_core_tx_serial, .o_radio_serial_out, .i_radio_serial_in,
    .o_core_rx_serial, .o_tx_permit, .i_flow_ctl_en, .i_rx_can_accept, .i_spi_slave_en,
    .i_spi_data_ready, .i_user_io, .o_user_io, .o_user_io_oe, .o_user_io_pullup, .o_user_io_in,
    .i_io_dir_out, .i_io_pullup, .i_io_poweron_level, .i_io_wr, .i_io_wr_level, .i_io_wake_en,
    .i_sleep, .i_sleep_dir_out, .i_sleep_pullup, .i_sleep_level, .i_adc_sample_tick, .o_wake);

  host_model i_host (.i_sys_clk, .i_reset, .i_cts_n(o_user_io[4]), .i_send(h_send),
    .i_bit(h_bit), .i_hold(h_hold), .o_txd(i_radio_serial_in), .o_rts_n(rts_n));

  initial begin
    i_sys_clk = 1'h0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task print_verdict;
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : cyc

  task automatic pulse(input logic [9:0] m);
    @(posedge i_sys_clk) ev <= m;
    @(posedge i_sys_clk) ev <= '0;
    #1;
  endtask : pulse

  task automatic wait_wake(input logic e);
    logic s;
    s = 1'h0;
    repeat (6) begin
      @(posedge i_sys_clk);
      #1;
      if (o_wake === 1'h1) s = 1'h1;
    end
    chk("wake", 8'(s), 8'(e));
    if (e && !s) print_verdict;
  endtask : wait_wake

  initial begin
    #200000;
    bad_count++;
    print_verdict;
  end

  initial begin
    {ev, i_role, i_diag_mode, i_diag_serial_out_data, i_flow_ctl_en, i_spi_slave_en} = '0;
    {i_spi_data_ready, i_sleep, h_send, h_bit, ext, ext_en, i_io_wr_level} = '0;
    {i_core_tx_serial, i_rx_can_accept, diag_pad, h_hold, i_reset} = '1;
    i_reg_timeout = 16'h0003;
    i_io_dir_out = 6'h15;
    i_io_poweron_level = 6'h05;
    i_io_pullup = 6'h2a;
    i_io_wake_en = 6'h06;
    i_sleep_dir_out = 6'h01;
    i_sleep_pullup = 6'h3e;
    i_sleep_level = 6'h01;
    cyc(4);
    chk("link_rst", 8'(o_link_up_n), 8'(host_signals_pkg::LINK_DOWN_N));
    @(posedge i_sys_clk) i_reset <= 1'h0;
    cyc(3);
    chk("io_oe", 8'(o_user_io_oe), 8'h15);
    chk("io_in", 8'(o_user_io_in), 8'h2f);
    chk("io_out", 8'(o_user_io & 6'h15), 8'h05);
    chk("io_pull", 8'(o_user_io_pullup), 8'h2a);
    @(posedge i_sys_clk) i_io_wr_level <= 6'h10;
    pulse(10'h200);
    cyc(2);
    chk("io_wr", 8'(o_user_io & 6'h15), 8'h10);
    for (int k = 0; k < 6; k++) begin
      @(posedge i_sys_clk) i_role <= t_role[k];
      cyc(ACT + 4);
      pulse(t_ev[k]);
      cyc(2);
      chk("traffic", 8'(o_traffic_indicator), 8'(t_on[k]));
    end
    // Second event lands before the first pulse would have ended
    @(posedge i_sys_clk) i_role <= host_signals_pkg::ROLE_BASE;
    pulse(10'h001);
    cyc(ACT - 3);
    pulse(10'h001);
    cyc(ACT - 3);
    chk("retrig", 8'(o_traffic_indicator), 8'h01);
    cyc(ACT);
    chk("act_end", 8'(o_traffic_indicator), 8'h00);
    // Mid-run reset drops the link so the base raise below is seen
    @(posedge i_sys_clk) i_reset <= 1'h1;
    cyc(2);
    chk("link_rst2", 8'(o_link_up_n), 8'(host_signals_pkg::LINK_DOWN_N));
    @(posedge i_sys_clk) i_reset <= 1'h0;
    cyc(2);
    pulse(10'h001);
    cyc(2);
    chk("base_up", 8'(o_link_up_n), 8'(host_signals_pkg::LINK_UP_N));
    repeat (2) pulse(10'h080);
    cyc(2);
    chk("base_hold", 8'(o_link_up_n), 8'(host_signals_pkg::LINK_UP_N));
    pulse(10'h080);
    cyc(2);
    chk("base_drop", 8'(o_link_up_n), 8'(host_signals_pkg::LINK_DOWN_N));
    @(posedge i_sys_clk) i_role <= host_signals_pkg::ROLE_REMOTE;
    pulse(10'h010);
    cyc(2);
    chk("rem_up", 8'(o_link_up_n), 8'(host_signals_pkg::LINK_UP_N));
    repeat (10) pulse(10'h020);
    pulse(10'h060);
    repeat (49) pulse(10'h020);
    cyc(2);
    chk("rem_49", 8'(o_link_up_n), 8'(host_signals_pkg::LINK_UP_N));
    pulse(10'h020);
    cyc(2);
    chk("rem_50", 8'(o_link_up_n), 8'(host_signals_pkg::LINK_DOWN_N));
    @(posedge i_sys_clk) {i_diag_mode, i_diag_serial_out_data, diag_pad} <= 3'h4;
    cyc(3);
    chk("diag_tx0", 8'(o_link_up_n), 8'h00);
    chk("diag_oe", 8'(o_traffic_indicator_oe), 8'h00);
    chk("diag_rx0", 8'(o_diag_serial_in_data), 8'h00);
    @(posedge i_sys_clk) {i_diag_mode, i_diag_serial_out_data, diag_pad} <= 3'h7;
    cyc(3);
    chk("diag_tx1", 8'(o_link_up_n), 8'h01);
    chk("diag_rx1", 8'(o_diag_serial_in_data), 8'h01);
    @(posedge i_sys_clk) {i_diag_mode, i_flow_ctl_en, i_core_tx_serial, h_send, h_hold} <= 5'h0a;
    cyc(4);
    chk("cts_ready", 8'(o_user_io[4]), 8'(host_signals_pkg::CTS_READY));
    chk("cts_oe", 8'(o_user_io_oe[4]), 8'h01);
    chk("host_in", 8'(o_core_rx_serial), 8'h00);
    chk("host_out", 8'(o_radio_serial_out), 8'h00);
    chk("permit", 8'(o_tx_permit), 8'h01);
    @(posedge i_sys_clk) {i_rx_can_accept, h_hold} <= 2'h1;
    cyc(4);
    chk("cts_busy", 8'(o_user_io[4]), 8'(host_signals_pkg::CTS_BUSY));
    chk("host_stop", 8'(o_core_rx_serial), 8'h01);
    chk("held_off", 8'(o_tx_permit), 8'h00);
    @(posedge i_sys_clk) {i_flow_ctl_en, i_rx_can_accept, h_send, i_spi_slave_en} <= 4'h5;
    i_spi_data_ready <= 1'h1;
    cyc(3);
    chk("pend_on", 8'({o_user_io_oe[3], o_user_io[3]}), 8'h03);
    @(posedge i_sys_clk) i_spi_data_ready <= 1'h0;
    cyc(3);
    chk("pend_off", 8'(o_user_io[3]), 8'h00);
    @(posedge i_sys_clk) {i_spi_slave_en, i_sleep} <= 2'h1;
    cyc(3);
    chk("slp_oe", 8'(o_user_io_oe), 8'h01);
    chk("slp_pull", 8'(o_user_io_pullup), 8'h3e);
    chk("slp_lvl", 8'(o_user_io[0]), 8'h01);
    @(posedge i_sys_clk) ext_en <= 6'h04;
    wait_wake(1'h0);
    @(posedge i_sys_clk) ev <= 10'h100;
    wait_wake(1'h1);
    @(posedge i_sys_clk) {ev, ext_en} <= '0;
    cyc(4);
    @(posedge i_sys_clk) ext_en <= 6'h02;
    wait_wake(1'h1);
    print_verdict;
  end
endmodule : tb
